// file: verilog/i2c_boot_slave.sv
/*
 * Boot-loader I2C slave: holds off after reset, stretches SCL after its address,
 * buffers received bytes, sends bytes for reads and watches a per-command timeout
 * that requests a system reset on expiry.
 * Assumes open-drain pins resolved outside; SCL and SDA are asynchronous inputs.
 */
`timescale 1ns/10ps
module i2c_boot_slave import i2c_boot_pkg::*; #(
    parameter logic [6:0] OWN_ADDR = 7'h3A,
    parameter bit ALT_VARIANT = 1'b0,
    parameter int TMO_CYC = TIMEOUT_CYC,
    parameter int BOOT_CYC = ALT_VARIANT ? BOOT_WAIT_ALT_CYC : BOOT_WAIT_CYC
) (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic reset, // async reset, active high
    input wire link_in_s link_in, // asynchronous SCL and SDA pin levels
    output link_out_s link_out, // open-drain drives, enables active low
    output logic [DATA_W-1:0] rx_data, // received byte
    output logic rx_valid, // received byte available
    input wire logic rx_ready, // consumer takes rx_data
    input wire logic [DATA_W-1:0] tx_data, // byte for the next read
    input wire logic tx_valid, // tx_data is offered
    output logic tx_taken, // pulse: tx_data was latched
    input wire logic cmd_done, // pulse: current command has completed
    output logic cmd_active, // a command is in progress
    output logic boot_done, // post-reset hold-off over
    output logic sys_reset_req // pulse: timeout expired
);
    localparam int STR_CYC = ALT_VARIANT ? STRETCH_ALT_CYC : STRETCH_CYC;
    localparam int RDY_CYC = ALT_VARIANT ? READY_ALT_CYC : READY_CYC;
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);
    localparam logic [TMO_W-1:0] BOOT_LAST = TMO_W'(BOOT_CYC - 1);
    localparam logic [STR_W-1:0] STR_LAST = STR_W'(STR_CYC - 1);
    localparam logic [SINCE_W-1:0] RDY_LAST = SINCE_W'(RDY_CYC - 1);

    slave_regs_s s, n;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_data;

    // edges read only the second sync stage and its delayed copy
    assign rise = s.scl_s & ~s.scl_p;
    assign fall = ~s.scl_s & s.scl_p;
    assign start = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
    assign stop = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
    // head word moves into the output stage when that stage is empty or being taken
    assign fifo_pop = fifo_valid && (!s.rx_valid || rx_ready);

    i2c_boot_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(s.push),
        .in_ready(fifo_ready),
        .in_data(s.sh),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    always_comb begin
        n = s;
        n.scl_m = link_in.scl;
        n.scl_s = s.scl_m;
        n.scl_p = s.scl_s;
        n.sda_m = link_in.sda;
        n.sda_s = s.sda_m;
        n.sda_p = s.sda_s;
        n.sys_reset = 1'b0;
        n.tx_taken = 1'b0;
        n.push = 1'b0;
        // one-word output stage so rx_valid and rx_data leave from flip-flops
        if (rx_ready) begin
            n.rx_valid = 1'b0;
        end
        if (fifo_pop) begin
            n.rx_valid = 1'b1;
            n.rx_data = fifo_data;
        end
        if (s.since != RDY_LAST) begin
            n.since = s.since + 1'b1;
        end
        if (s.cmd_active) begin
            n.tmo = s.tmo + 1'b1;
        end

        // stop the timeout; an address ack in the same cycle still sets cmd_active
        if (cmd_done) begin
            n.cmd_active = 1'b0;
            n.tmo = '0;
        end

        case (s.state)
            ST_BOOT: begin
                // bus ignored until the host's post-reset wait is over
                n.tmo = s.tmo + 1'b1;
                if (s.tmo == BOOT_LAST) begin
                    n.tmo = '0;
                    n.boot_done = 1'b1;
                    n.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                n.link.sda_oe_n = 1'b1;
                n.link.scl_oe_n = 1'b1;
            end
            ST_ADDR: begin
                if (rise && s.bits != BITS_BYTE) begin
                    n.sh = {s.sh[DATA_W-2:0], s.sda_s};
                    n.bits = s.bits + 1'b1;
                end
                if (fall && s.bits == BITS_BYTE) begin
                    if (s.sh[7:1] == OWN_ADDR) begin
                        n.rw = s.sh[0];
                        n.link.sda_oe_n = 1'b0;
                        n.cmd_active = 1'b1;
                        n.tmo = '0;
                        n.state = ST_AACK;
                    end else begin
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_AACK: begin
                if (fall) begin
                    n.link.sda_oe_n = 1'b1;
                    n.link.scl_oe_n = 1'b0;
                    n.str_cnt = '0;
                    n.state = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                n.link.scl_oe_n = 1'b0;
                if (s.str_cnt != STR_LAST) begin
                    n.str_cnt = s.str_cnt + 1'b1;
                end
                // release only after both the stretch and the readiness time
                if (s.str_cnt == STR_LAST && s.since == RDY_LAST) begin
                    n.bits = 4'h0;
                    if (s.rw) begin
                        n.state = ST_TLOAD;
                    end else begin
                        n.link.scl_oe_n = 1'b1;
                        n.state = ST_RX;
                    end
                end
            end
            ST_RX: begin
                if (rise && s.bits != BITS_BYTE) begin
                    n.sh = {s.sh[DATA_W-2:0], s.sda_s};
                    n.bits = s.bits + 1'b1;
                end
                if (!s.scl_s && s.bits == BITS_BYTE) begin
                    if (fifo_ready) begin
                        n.push = 1'b1;
                        n.link.sda_oe_n = 1'b0;
                        n.link.scl_oe_n = 1'b1;
                        n.tmo = '0;
                        n.state = ST_RACK;
                    end else begin
                        // full buffer: hold the clock low until space frees
                        n.link.scl_oe_n = 1'b0;
                    end
                end
            end
            ST_RACK: begin
                if (fall) begin
                    n.link.sda_oe_n = 1'b1;
                    n.bits = 4'h0;
                    n.state = ST_RX;
                end
            end
            ST_TLOAD: begin
                n.link.scl_oe_n = 1'b0;
                if (tx_valid) begin
                    n.sh = tx_data;
                    n.tx_taken = 1'b1;
                    n.link.sda_oe_n = tx_data[DATA_W-1];
                    n.bits = 4'h0;
                    n.tack = 1'b0;
                    n.state = ST_TX;
                end
            end
            ST_TX: begin
                // clock released one cycle after the first bit is set up
                n.link.scl_oe_n = 1'b1;
                if (s.tack) begin
                    if (rise) begin
                        if (s.sda_s) begin
                            n.state = ST_IDLE;
                        end else begin
                            n.bits = BITS_ACKED;
                        end
                    end
                    if (fall && s.bits == BITS_ACKED) begin
                        n.link.scl_oe_n = 1'b0;
                        n.state = ST_TLOAD;
                    end
                end else begin
                    if (rise) begin
                        n.bits = s.bits + 1'b1;
                    end
                    if (fall) begin
                        if (s.bits == BITS_BYTE) begin
                            n.link.sda_oe_n = 1'b1;
                            n.tack = 1'b1;
                            n.bits = 4'h0;
                            n.tmo = '0;
                        end else begin
                            n.sh = {s.sh[DATA_W-2:0], 1'b0};
                            n.link.sda_oe_n = s.sh[DATA_W-2];
                        end
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        if (s.state != ST_BOOT) begin
            if (start) begin
                n.state = ST_ADDR;
                n.bits = 4'h0;
                n.since = '0;
                n.link.sda_oe_n = 1'b1;
                n.link.scl_oe_n = 1'b1;
                if (s.cmd_active) begin
                    n.tmo = '0;
                end
            end else if (stop) begin
                n.state = ST_IDLE;
                n.link.sda_oe_n = 1'b1;
                n.link.scl_oe_n = 1'b1;
            end
        end

        if (s.cmd_active && s.tmo == TMO_LAST) begin
            // expiry wins over traffic in the same cycle, except that push and tx_taken still pulse
            n.sys_reset = 1'b1;
            n.cmd_active = 1'b0;
            n.tmo = '0;
            n.state = ST_IDLE;
            n.link.sda_oe_n = 1'b1;
            n.link.scl_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= SLAVE_RESET;
        end else begin
            s <= n;
        end
    end

    assign link_out = s.link;
    assign tx_taken = s.tx_taken;
    assign cmd_active = s.cmd_active;
    assign boot_done = s.boot_done;
    assign sys_reset_req = s.sys_reset;
    assign rx_valid = s.rx_valid;
    assign rx_data = s.rx_data;
endmodule

// file: shared/i2c_boot_pkg.sv
/*
 * Constants, timing figures, carrier structs and state types for the boot-loader
 * I2C slave timing block and its receive FIFO.
 * Assumes one 100 MHz system clock; pin levels arrive unsynchronised.
 */
// Summary of operation
// - after acknowledging its address the slave stretches SCL about 0.0055 ms.
// - slave ready no earlier than start plus byte time plus stretch, 0.028 ms.
// - a 10 ms timeout runs between successive frames of one command.
// - the same timeout runs between successive bytes inside one frame.
// - timeout expiry raises a system reset and abandons the command.
// - alternative variant uses 0.0054 ms stretch, 0.0279 ms ready, 1.5411 ms wait.
package i2c_boot_pkg;

    localparam int CLK_NS = 10;

    // times in ns, figures as printed in ms scaled to ns
    localparam int BOOT_WAIT_NS = 1542000;
    localparam int BOOT_WAIT_ALT_NS = 1541100;
    localparam int STRETCH_NS = 5500;
    localparam int STRETCH_ALT_NS = 5400;
    localparam int READY_NS = 28000;
    localparam int READY_ALT_NS = 27900;
    localparam int TIMEOUT_NS = 10000000;

    // least time rounded up to whole cycles, never below one
    function automatic int cycles_ceil(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int BOOT_WAIT_CYC = cycles_ceil(BOOT_WAIT_NS);
    localparam int BOOT_WAIT_ALT_CYC = cycles_ceil(BOOT_WAIT_ALT_NS);
    localparam int STRETCH_CYC = cycles_ceil(STRETCH_NS);
    localparam int STRETCH_ALT_CYC = cycles_ceil(STRETCH_ALT_NS);
    localparam int READY_CYC = cycles_ceil(READY_NS);
    localparam int READY_ALT_CYC = cycles_ceil(READY_ALT_NS);
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int TMO_W = 20;
    localparam int SINCE_W = 12;
    localparam int STR_W = 10;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_ACKED = 4'h1;

    typedef struct packed {
        logic scl;
        logic sda;
    } link_in_s;

    typedef struct packed {
        logic scl_o;
        logic scl_oe_n;
        logic sda_o;
        logic sda_oe_n;
    } link_out_s;

    typedef enum logic [8:0] {
        ST_BOOT = 9'h001,
        ST_IDLE = 9'h002,
        ST_ADDR = 9'h004,
        ST_AACK = 9'h008,
        ST_STRETCH = 9'h010,
        ST_RX = 9'h020,
        ST_RACK = 9'h040,
        ST_TLOAD = 9'h080,
        ST_TX = 9'h100
    } slave_state_e;

    // no ST_TACK code; the ack phase is the tack flag in ST_TX and ST_TACK_FALLBACK aliases ST_IDLE
    localparam slave_state_e ST_TACK_FALLBACK = ST_IDLE;

    typedef struct packed {
        slave_state_e state;
        logic tack;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [DATA_W-1:0] sh;
        logic [3:0] bits;
        logic rw;
        logic [STR_W-1:0] str_cnt;
        logic [SINCE_W-1:0] since;
        logic [TMO_W-1:0] tmo;
        logic cmd_active;
        logic boot_done;
        logic sys_reset;
        logic tx_taken;
        logic push;
        logic rx_valid;
        logic [DATA_W-1:0] rx_data;
        link_out_s link;
    } slave_regs_s;

    localparam slave_regs_s SLAVE_RESET = '{
        state: ST_BOOT, tack: 1'b0,
        scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
        sh: 8'h00, bits: 4'h0, rw: 1'b0,
        str_cnt: 10'h000, since: 12'h000, tmo: 20'h00000,
        cmd_active: 1'b0, boot_done: 1'b0, sys_reset: 1'b0,
        tx_taken: 1'b0, push: 1'b0, rx_valid: 1'b0, rx_data: 8'h00,
        link: '{scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1}
    };

endpackage

// file: verilog/i2c_boot_fifo.sv
/*
 * Receive FIFO with valid/ready on both sides, width and depth as parameters.
 * Assumes both sides run on sys_clk.
 */
`timescale 1ns/10ps
module i2c_boot_fifo import i2c_boot_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic in_valid, // write strobe
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // not empty
    input wire logic out_ready, // reader takes the head word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0] wr;
        logic [PW:0] rd;
    } fifo_regs_s;

    fifo_regs_s s, n;
    logic full;
    logic empty;

    assign empty = (s.wr == s.rd);
    assign full = (s.wr[PW-1:0] == s.rd[PW-1:0]) && (s.wr[PW] != s.rd[PW]);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = s.mem[s.rd[PW-1:0]];

    always_comb begin
        n = s;
        if (in_valid && !full) begin
            n.mem[s.wr[PW-1:0]] = in_data;
            n.wr = s.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            n.rd = s.rd + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule

// file: bench/i2c_boot_slave_monitor.sv
/* Port-level timing checker for the boot I2C slave.
   Assumes a bind to i2c_boot_slave; sees its ports only. */
`timescale 1ns/10ps
module i2c_boot_slave_monitor import i2c_boot_pkg::*; #(
    parameter int TMO_CYC = TIMEOUT_CYC,
    parameter int BOOT_CYC = BOOT_WAIT_CYC,
    parameter int RDY_CYC = READY_CYC
) (
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset
    input wire link_in_s link_in, // pin levels
    input wire link_out_s link_out, // pin drives
    input wire logic cmd_done, // command end
    input wire logic cmd_active, // command running
    input wire logic boot_done, // hold-off over
    input wire logic sys_reset_req // timeout reset
);
    logic [31:0] boot_cnt_r;
    logic [31:0] quiet_r;
    logic [31:0] since_r;
    logic done_r;
    logic st;
    link_in_s prev_r;
    assign st = prev_r.sda && !link_in.sda && link_in.scl;
    // quiet: cycles without clock edges while a command runs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            boot_cnt_r <= '0;
            quiet_r <= '0;
            since_r <= '0;
            done_r <= 1'b0;
            prev_r <= '1;
        end else begin
            prev_r <= link_in;
            boot_cnt_r <= boot_cnt_r + 32'h1;
            done_r <= cmd_done || (done_r && !st);
            if (!cmd_active || done_r || cmd_done || prev_r.scl != link_in.scl) begin
                quiet_r <= '0;
            end else begin
                quiet_r <= quiet_r + 32'h1;
            end
            since_r <= st ? '0 : since_r + 32'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    boot_hold_a: assert property (!boot_done |-> link_out.scl_oe_n && link_out.sda_oe_n)
        else $error("link driven during hold-off");
    boot_time_a: assert property ($rose(boot_done) |-> boot_cnt_r == BOOT_CYC)
        else $error("hold-off length wrong");
    open_drain_a: assert property (link_out.scl_o == 1'b0 && link_out.sda_o == 1'b0)
        else $error("line driven high");
    ready_delay_a: assert property ($rose(link_out.scl_oe_n) |-> since_r >= RDY_CYC)
        else $error("clock released too early after start");
    tmo_window_a: assert property (sys_reset_req |-> quiet_r inside {[TMO_CYC-100:TMO_CYC+8]})
        else $error("timeout expiry at wrong time");
    tmo_bound_a: assert property (cmd_active && !done_r |-> quiet_r <= TMO_CYC + 8)
        else $error("timeout overdue");
    reset_pulse_a: assert property (sys_reset_req |=> !sys_reset_req && !cmd_active)
        else $error("reset request not a single pulse");
    reset_free_a: assert property (sys_reset_req |-> ##[0:1] link_out.scl_oe_n && link_out.sda_oe_n)
        else $error("lines held after timeout");
    cmd_ack_a: assert property ($rose(cmd_active) |-> ##[0:4] !link_out.sda_oe_n)
        else $error("command started without ack");
endmodule
bind i2c_boot_slave i2c_boot_slave_monitor #(
    .TMO_CYC(TMO_CYC), .BOOT_CYC(BOOT_CYC), .RDY_CYC(RDY_CYC)) i_mon (
    .sys_clk(sys_clk), .reset(reset), .link_in(link_in), .link_out(link_out),
    .cmd_done(cmd_done), .cmd_active(cmd_active), .boot_done(boot_done),
    .sys_reset_req(sys_reset_req));

// file: bench/i2c_boot_host.sv
/* Host I2C master model, open-drain, 80 ns bit period.
   Assumes the bench resolves both lines with pull-ups. */
`timescale 1ns/10ps
module i2c_boot_host (
    input wire logic scl, // resolved clock line
    input wire logic sda, // resolved data line
    output logic scl_drv, // 0 pulls clock low
    output logic sda_drv, // 0 pulls data low
    output logic hung // stretch never ended
);
    time t_start;
    time t_ackf;
    time t_rise;
    time t_gap;
    time t_ready;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        hung = 1'b0;
        t_ackf = 0;
    end
    // waits out slave stretching, bounded
    task automatic rel_scl();
        scl_drv = 1'b1;
        for (int i = 0; i < 10000 && scl !== 1'b1; i++) #10;
        if (scl !== 1'b1) hung = 1'b1;
        t_rise = $time;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        #20;
        rel_scl();
        #20;
        sda_drv = 1'b0;
        t_start = $time;
        #20;
        scl_drv = 1'b0;
        #20;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #20;
        rel_scl();
        #20;
        sda_drv = 1'b1;
        #40;
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #20;
        rel_scl();
        #20;
        s = sda;
        #20;
        scl_drv = 1'b0;
        #20;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            if (i == 7) begin
                t_gap = t_rise - t_ackf;
                t_ready = t_rise - t_start;
            end
        end
        bit_io(1'b1, ack);
        t_ackf = $time - 20;
    endtask
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, s);
    endtask
endmodule

// file: bench/i2c_boot_slave_timing_tb.sv
/* Self-checking bench for the boot I2C slave with a host model on the link.
   Assumes pull-ups on both lines, resolved here from all drivers. */
`timescale 1ns/10ps
module i2c_boot_slave_timing_tb import i2c_boot_pkg::*; ;
    localparam int TMO = 5000;
    localparam int BOOT = 50;
    localparam logic [6:0] ADDR = 7'h3A;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic rx_ready = 1'b1;
    logic tx_valid = 1'b0;
    logic cmd_done = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic host_scl, host_sda, hung, scl_w, sda_w, ack;
    logic rx_valid, tx_taken, cmd_active, boot_done, sys_reset_req;
    logic [7:0] rx_data, rd, b;
    link_in_s link_in;
    link_out_s link_out;
    link_out_s link_alt;
    int n_errors = 0;
    int total_checks = 0;
    int n_rst = 0;
    int n_tx = 0;
    logic [7:0] rx_q[$];
    assign scl_w = host_scl & (link_out.scl_oe_n | link_out.scl_o)
        & (link_alt.scl_oe_n | link_alt.scl_o);
    assign sda_w = host_sda & (link_out.sda_oe_n | link_out.sda_o)
        & (link_alt.sda_oe_n | link_alt.sda_o);
    assign link_in = '{scl: scl_w, sda: sda_w};
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    i2c_boot_host i_host (.scl(scl_w), .sda(sda_w), .scl_drv(host_scl), .sda_drv(host_sda),
        .hung(hung));
    i2c_boot_slave #(.OWN_ADDR(ADDR), .TMO_CYC(TMO), .BOOT_CYC(BOOT)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .link_in(link_in), .link_out(link_out),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_taken(tx_taken), .cmd_done(cmd_done),
        .cmd_active(cmd_active), .boot_done(boot_done), .sys_reset_req(sys_reset_req));
    // second slave on the same lines runs the alternative stretch and ready figures
    i2c_boot_slave #(.OWN_ADDR(ADDR ^ 7'h10), .ALT_VARIANT(1'b1), .TMO_CYC(TMO), .BOOT_CYC(BOOT))
        i_alt (
        .sys_clk(sys_clk), .reset(reset), .link_in(link_in), .link_out(link_alt),
        .rx_data(), .rx_valid(), .rx_ready(1'b1), .tx_data(8'h00), .tx_valid(1'b0),
        .tx_taken(), .cmd_done(cmd_done), .cmd_active(), .boot_done(), .sys_reset_req());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic addr(input logic [6:0] a, input logic rw, input logic exp);
        cyc(1);
        i_host.start();
        i_host.send_byte({a, rw}, ack);
        check(32'(ack), 32'(exp));
    endtask
    // scoreboard: oldest noted byte against each popped byte
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            check(32'(rx_data), 32'(rx_q.pop_front()));
        end
        if (sys_reset_req === 1'b1) n_rst++;
        if (tx_taken === 1'b1) n_tx++;
        if (hung === 1'b1) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        int k;
        void'($urandom(32'h3655F7D2));
        cyc(4);
        check(32'({link_out.scl_oe_n, link_out.sda_oe_n, boot_done, rx_valid}), 32'hC);
        @(posedge sys_clk) reset <= 1'b0;
        addr(ADDR, 1'b0, 1'b1);
        i_host.stop();
        for (k = 0; k < 300 && boot_done !== 1'b1; k++) cyc(1);
        check(32'(boot_done), 32'h1);
        addr(ADDR ^ 7'h01, 1'b0, 1'b1);
        check(32'(cmd_active), 32'h0);
        i_host.stop();
        $display("test boot and address done");
        addr(ADDR, 1'b0, 1'b0);
        check(32'(cmd_active), 32'h1);
        for (int i = 0; i < 38; i++) begin
            b = 8'($urandom);
            rx_q.push_back(b);
            if (i == 4) begin
                @(posedge sys_clk) rx_ready <= 1'b0;
                cyc(1);
            end
            if (i == 37) begin
                fork
                    i_host.send_byte(b, ack);
                    begin
                        cyc(300);
                        check(32'(scl_w), 32'h0);
                        check(32'(rx_valid), 32'h1);
                        @(posedge sys_clk) rx_ready <= 1'b1;
                    end
                join
            end else begin
                i_host.send_byte(b, ack);
            end
            check(32'(ack), 32'h0);
            if (i == 0) begin
                check(32'(i_host.t_gap >= STRETCH_NS), 32'h1);
                check(32'(i_host.t_ready >= READY_NS), 32'h1);
            end
        end
        for (k = 0; k < 300 && rx_q.size() > 0; k++) cyc(1);
        cyc(3);
        check(32'({rx_q.size() == 0, rx_valid}), 32'h2);
        $display("test write and buffer done");
        addr(ADDR, 1'b1, 1'b0);
        for (int i = 0; i < 2; i++) begin
            b = 8'($urandom);
            @(posedge sys_clk);
            tx_data <= b;
            tx_valid <= 1'b1;
            cyc(1);
            fork
                i_host.recv_byte(i == 1, rd);
                begin
                    for (k = 0; k < 4000 && tx_taken !== 1'b1; k++) cyc(1);
                    @(posedge sys_clk) tx_valid <= 1'b0;
                end
            join
            check(32'(rd), 32'(b));
        end
        check(32'(n_tx), 32'h2);
        i_host.stop();
        @(posedge sys_clk) cmd_done <= 1'b1;
        @(posedge sys_clk) cmd_done <= 1'b0;
        cyc(TMO + 200);
        check(32'(n_rst), 32'h0);
        $display("test read and completion done");
        addr(ADDR ^ 7'h10, 1'b0, 1'b0);
        i_host.send_byte(8'($urandom), ack);
        check(32'(ack), 32'h0);
        check(32'(i_host.t_gap >= STRETCH_ALT_NS), 32'h1);
        check(32'(i_host.t_ready >= READY_ALT_NS), 32'h1);
        check(32'(i_host.t_ready < READY_NS), 32'h1);
        i_host.stop();
        @(posedge sys_clk) cmd_done <= 1'b1;
        @(posedge sys_clk) cmd_done <= 1'b0;
        $display("test alternative variant done");
        addr(ADDR, 1'b0, 1'b0);
        b = 8'($urandom);
        rx_q.push_back(b);
        i_host.send_byte(b, ack);
        i_host.stop();
        for (k = 0; k < TMO + 200 && n_rst == 0; k++) cyc(1);
        check(32'(k >= TMO - 200), 32'h1);
        check(32'({n_rst == 1, cmd_active}), 32'h2);
        $display("test timeout done");
        end_sim();
    end
endmodule
